// file: gst_pkg.sv
/*
 * Package for the gated sixteen-bit timer pair: register offsets, field
 * positions, reset values and the shared bus carrier types.
 * Assumes a single 200 MHz clock domain and an Avalon-MM master.
 */
`default_nettype none

package gst_pkg;

	// register word byte addresses
	localparam logic [5:0] GST_OFS_CTRL0 = 6'h00;
	localparam logic [5:0] GST_OFS_GATE0 = 6'h04;
	localparam logic [5:0] GST_OFS_CNTL0 = 6'h08;
	localparam logic [5:0] GST_OFS_CNTH0 = 6'h0C;
	localparam logic [5:0] GST_OFS_CTRL1 = 6'h10;
	localparam logic [5:0] GST_OFS_GATE1 = 6'h14;
	localparam logic [5:0] GST_OFS_CNTL1 = 6'h18;
	localparam logic [5:0] GST_OFS_CNTH1 = 6'h1C;
	localparam logic [5:0] GST_OFS_STAT = 6'h20;
	localparam logic [5:0] GST_OFS_MASK = 6'h24;
	localparam logic [5:0] GST_OFS_XOSC = 6'h28;

	// counter_control_reg fields
	localparam int GST_CTL_RUN = 0;
	localparam int GST_CTL_SYNCDIS = 2;
	localparam int GST_CTL_PS_LO = 4;
	localparam int GST_CTL_CS_LO = 6;
	// gate_control_reg fields
	localparam int GST_GCT_GE = 7;
	localparam int GST_GCT_POL = 6;
	// crystal oscillator control field
	localparam int GST_XOSC_EN = 0;
	// status / mask bits: overflow 0, overflow 1
	localparam int GST_IRQ_OVF0 = 0;
	localparam int GST_IRQ_OVF1 = 1;

	localparam logic [7:0] GST_CTRL_RST = 8'h00;
	localparam logic [7:0] GST_GATE_RST = 8'h00;
	localparam logic [1:0] GST_IRQ_RST = 2'h0;

	// source select encodings
	localparam logic [1:0] GST_CS_INSTR = 2'h0;
	localparam logic [1:0] GST_CS_SYS = 2'h1;
	localparam logic [1:0] GST_CS_EXT = 2'h2;
	localparam logic [1:0] GST_CS_SENSE = 2'h3;

	// instruction cycle is four system clocks
	localparam logic [1:0] GST_INSTR_DIV = 2'h3;

	typedef struct packed {
		logic [5:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} gst_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} gst_rsp_s;

endpackage : gst_pkg

`default_nettype wire

// file: gst_timer_pair.sv
/*
 * Two sixteen-bit gated up-counters with source select, 1/2/4/8 prescaler,
 * overflow interrupts and a shared crystal oscillator enable, behind an
 * Avalon-MM slave. Assumes every pin input is asynchronous to i_mclk and
 * that the crystal/sense oscillators are outside, delivered as levels.
 */
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] Sixteen-bit up-counter, written as low and high bytes, write takes effect at once.
// [R2] Internal source makes a timer stepping once per instruction cycle, after prescale.
// [R3] External source counts each selected edge, as timer or event counter.
// [R4] Run bit clear means off; gate-enable set makes counting depend on gate.
// [R5] Source field: 01 system, 00 instruction, 11 sense, 10 pin or crystal.
// [R6] Internal source steps at multiples of system clock period per prescaler.
// [R7] Pin or sense source counts rising edges, synchronised or asynchronous mode.
// [R8] Sense source: first counter uses channel A, second channel B.
// [R9] Counter mode needs a falling edge before first counted rising edge after events.
// [R10] Chosen clock divided by 1, 2, 4 or 8 from prescale field.
// [R11] Prescale counter hidden from software, cleared on any count byte write.
// [R12] One crystal oscillator, enabled by its bit, can clock either or both counters.
// [R13] Crystal oscillator keeps running through Sleep once enabled.
// [R14] Software enables oscillator and waits for start-up before using it.
// [R15] Overflow wakes from Sleep only with external clock in asynchronous mode.
// [R16] Only the first counter serves capture/compare and its special event trigger.
// [R17] Sync-disable bypasses synchroniser; counter runs in Sleep and can wake on overflow; here it only enables wake, the synchronised path stays.
// [R18] Gated mode counts only while gate is active at its polarity.
// [R19] Rollover sets sticky overflow flag, interrupt raised when enabled.
module gst_timer_pair
	import gst_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// avalon-mm slave
	input wire gst_req_s i_req,
	output gst_rsp_s o_rsp,
	// pins and oscillators (asynchronous)
	input wire logic [1:0] i_external_count_pin,
	input wire logic i_crystal_input_pin,
	input wire logic i_sense_osc_channel_a,
	input wire logic i_sense_osc_channel_b,
	input wire logic [1:0] i_gate_input,
	// system
	input wire logic i_sleep,
	input wire logic i_ccp_special_trigger,
	// outputs
	output logic o_crystal_output_pin,
	output logic o_crystal_osc_enable,
	output logic [15:0] o_ccp_time_base,
	output logic o_irq,
	output logic o_wake
);

	function automatic logic is_ofs(input logic [5:0] a, input logic [5:0] o);
		is_ofs = (a == o);
	endfunction : is_ofs

	logic [7:0] ctrl [2];
	logic [7:0] gate_ctrl [2];
	logic [15:0] count [2];
	logic [1:0] status;
	logic [1:0] mask;
	logic xosc_en;
	logic [1:0] instr_div;
	logic [1:0] ovf_evt;
	logic [1:0] wr_cnt;
	logic [1:0] can_wake;
	logic wr_acc;
	logic rd_acc;
	logic rd_pend;
	logic [31:0] rdata;

	// crystal drive and enable
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			xosc_en <= 1'b0;
		end else if (wr_acc && is_ofs(i_req.address, GST_OFS_XOSC)) begin
			xosc_en <= i_req.writedata[GST_XOSC_EN];
		end
	end
	// the oscillator is analog; this only gates its amplifier, sleep has no say [R13]
	assign o_crystal_output_pin = xosc_en & ~i_crystal_input_pin;
	assign o_crystal_osc_enable = xosc_en;

	// instruction clock tick generator
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			instr_div <= 2'h0;
		end else begin
			instr_div <= instr_div + 2'h1;
		end
	end

	// synchroniser shared: crystal only; sense a/b are synchronised per counter
	logic [1:0] xin_s;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			xin_s <= 2'h0;
		end else begin
			xin_s <= {xin_s[0], i_crystal_input_pin};
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tmr
			logic [1:0] pin_s;
			logic [1:0] sen_s;
			logic [1:0] gat_s;
			logic ext_prev;
			logic armed;
			logic run_prev;
			logic [2:0] pre;
			logic ext_lvl;
			logic rise;
			logic clr;
			logic tick;
			logic gate_ok;
			logic enable;
			logic step;
			logic [1:0] cs;
			logic [1:0] ps;

			assign cs = ctrl[g][GST_CTL_CS_LO +: 2];
			assign ps = ctrl[g][GST_CTL_PS_LO +: 2];

			always_ff @(posedge i_mclk) begin
				if (i_srst) begin
					pin_s <= 2'h0;
					sen_s <= 2'h0;
					gat_s <= 2'h0;
				end else begin
					pin_s <= {pin_s[0], i_external_count_pin[g]};
					sen_s <= {sen_s[0], (g == 0) ? i_sense_osc_channel_a
						: i_sense_osc_channel_b}; // [R8]
					gat_s <= {gat_s[0], i_gate_input[g]};
				end
			end

			// pin vs crystal chosen by oscillator enable [R5] [R12]
			assign ext_lvl = (cs == GST_CS_SENSE) ? sen_s[1]
				: (xosc_en ? xin_s[1] : pin_s[1]); // [R5] [R7]

			// gate polarity and enable [R4] [R18]
			assign gate_ok = ~gate_ctrl[g][GST_GCT_GE]
				| (gat_s[1] == gate_ctrl[g][GST_GCT_POL]);
			assign enable = ctrl[g][GST_CTL_RUN] & gate_ok; // [R4]

			// falling-edge arming for counter mode [R9]
			always_ff @(posedge i_mclk) begin
				if (i_srst) begin
					ext_prev <= 1'b0;
					armed <= 1'b0;
					run_prev <= 1'b0;
				end else begin
					ext_prev <= ext_lvl;
					run_prev <= ctrl[g][GST_CTL_RUN];
					if (wr_cnt[g] || !ctrl[g][GST_CTL_RUN]
						|| (ctrl[g][GST_CTL_RUN] && !run_prev)) begin
						armed <= 1'b0; // [R9]
					end else if (ext_prev && !ext_lvl) begin
						armed <= 1'b1; // [R9]
					end
				end
			end
			assign rise = ~ext_prev & ext_lvl & armed; // [R3] [R7]

			// source tick before prescale [R2] [R5] [R6]
			always_comb begin
				case (cs)
					GST_CS_SYS: tick = 1'b1;
					GST_CS_INSTR: tick = (instr_div == GST_INSTR_DIV);
					GST_CS_EXT, GST_CS_SENSE: tick = rise;
					default: tick = 1'b0;
				endcase
			end

			// prescaler, cleared by count writes [R10] [R11]
			always_ff @(posedge i_mclk) begin
				if (i_srst || wr_cnt[g]) begin
					pre <= 3'h0; // [R11]
				end else if (enable && tick) begin
					pre <= pre + 3'h1;
				end
			end
			assign step = enable & tick & ((pre & ((3'h1 << ps) - 3'h1)) == ((3'h1 << ps)
				- 3'h1)); // [R10]

			// counter with byte writes [R1]
			always_ff @(posedge i_mclk) begin
				if (i_srst) begin
					count[g] <= 16'h0000;
				end else if (wr_acc && is_ofs(i_req.address, (g == 0) ? GST_OFS_CNTL0
					: GST_OFS_CNTL1)) begin
					count[g][7:0] <= i_req.writedata[7:0]; // [R1]
				end else if (wr_acc && is_ofs(i_req.address, (g == 0) ? GST_OFS_CNTH0
					: GST_OFS_CNTH1)) begin
					count[g][15:8] <= i_req.writedata[7:0]; // [R1]
				end else if (clr) begin
					count[g] <= 16'h0000; // [R16]
				end else if (step) begin
					count[g] <= count[g] + 16'h0001;
				end
			end
			// special event trigger reaches the first counter only [R16]
			assign clr = (g == 0) & i_ccp_special_trigger;
			// a write or trigger in the rollover cycle replaces the increment
			assign ovf_evt[g] = step & ~wr_cnt[g] & ~clr & (count[g] == 16'hFFFF); // [R19]
			assign wr_cnt[g] = wr_acc && (is_ofs(i_req.address, (g == 0) ? GST_OFS_CNTL0
				: GST_OFS_CNTL1) || is_ofs(i_req.address, (g == 0) ? GST_OFS_CNTH0
				: GST_OFS_CNTH1));
			// wake only external and async [R15] [R17]
			assign can_wake[g] = cs[1] & ctrl[g][GST_CTL_SYNCDIS];

			// control registers
			always_ff @(posedge i_mclk) begin
				if (i_srst) begin
					ctrl[g] <= GST_CTRL_RST;
					gate_ctrl[g] <= GST_GATE_RST;
				end else if (wr_acc) begin
					if (is_ofs(i_req.address, (g == 0) ? GST_OFS_CTRL0 : GST_OFS_CTRL1)) begin
						ctrl[g] <= i_req.writedata[7:0];
					end
					if (is_ofs(i_req.address, (g == 0) ? GST_OFS_GATE0 : GST_OFS_GATE1)) begin
						gate_ctrl[g] <= i_req.writedata[7:0];
					end
				end
			end
		end
	endgenerate

	// the synchronised path is used in both modes; async only changes wake policy
	// time base only from the first counter [R16]
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_ccp_time_base <= 16'h0000;
		end else begin
			o_ccp_time_base <= count[0]; // [R16]
		end
	end

	// sticky overflow flags, read clears, set wins [R19]
	logic rd_stat;
	assign rd_stat = rd_acc && is_ofs(i_req.address, GST_OFS_STAT);
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			status <= GST_IRQ_RST;
		end else begin
			status <= (rd_stat ? 2'h0 : status) | ovf_evt; // [R19]
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			mask <= GST_IRQ_RST;
		end else if (wr_acc && is_ofs(i_req.address, GST_OFS_MASK)) begin
			mask <= i_req.writedata[1:0];
		end
	end
	assign o_irq = |(status & mask); // [R19]
	assign o_wake = i_sleep & |(status & mask & can_wake); // [R15] [R17]

	// bus: reads take one wait cycle, writes none
	assign wr_acc = i_req.write;
	assign rd_acc = i_req.read & rd_pend;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rd_pend <= 1'b0;
		end else begin
			rd_pend <= i_req.read & ~rd_pend;
		end
	end
	// one driver for the whole response: flopped data, combinational wait
	assign o_rsp = '{readdata: rdata, waitrequest: i_req.read & ~rd_pend};

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rdata <= 32'h0000_0000;
		end else if (i_req.read && !rd_pend) begin
			case (i_req.address)
				GST_OFS_CTRL0: rdata <= {24'h0, ctrl[0]};
				GST_OFS_GATE0: rdata <= {24'h0, gate_ctrl[0]};
				GST_OFS_CNTL0: rdata <= {24'h0, count[0][7:0]};
				GST_OFS_CNTH0: rdata <= {24'h0, count[0][15:8]};
				GST_OFS_CTRL1: rdata <= {24'h0, ctrl[1]};
				GST_OFS_GATE1: rdata <= {24'h0, gate_ctrl[1]};
				GST_OFS_CNTL1: rdata <= {24'h0, count[1][7:0]};
				GST_OFS_CNTH1: rdata <= {24'h0, count[1][15:8]};
				GST_OFS_STAT: rdata <= {30'h0, status | ovf_evt};
				GST_OFS_MASK: rdata <= {30'h0, mask};
				GST_OFS_XOSC: rdata <= {31'h0, xosc_en};
				default: rdata <= 32'h0000_0000;
			endcase
		end
	end

	// assertions
	property p_off_holds;
		@(posedge i_mclk) disable iff (i_srst)
		(!ctrl[0][GST_CTL_RUN] && !wr_cnt[0] && !i_ccp_special_trigger) |=> $stable(count[0]);
	endproperty
	a_off_holds: assert property (p_off_holds) else $error("count moved while off"); // [R4]

	property p_sys_counts;
		@(posedge i_mclk) disable iff (i_srst)
		(ctrl[0] == 8'h41 && !gate_ctrl[0][GST_GCT_GE] && !wr_acc && !i_ccp_special_trigger)
			|=> count[0] == $past(count[0]) + 16'h0001;
	endproperty
	a_sys_counts: assert property (p_sys_counts) else $error("system source missed a step"); // [R5]

	property p_wr_low;
		@(posedge i_mclk) disable iff (i_srst)
		(wr_acc && i_req.address == GST_OFS_CNTL0) |=> count[0][7:0] == $past(i_req.writedata[7:0]);
	endproperty
	a_wr_low: assert property (p_wr_low) else $error("low byte write lost"); // [R1]

	property p_pre_clr;
		@(posedge i_mclk) disable iff (i_srst)
		wr_cnt[1] |=> g_tmr[1].pre == 3'h0;
	endproperty
	a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared"); // [R11]

	property p_ovf_sticky;
		@(posedge i_mclk) disable iff (i_srst)
		(ovf_evt[0] || (status[0] && !rd_stat)) |=> status[0];
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag not held"); // [R19]

	property p_irq;
		@(posedge i_mclk) disable iff (i_srst)
		(status[1] && mask[1]) |-> o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing"); // [R19]

	property p_arm;
		@(posedge i_mclk) disable iff (i_srst)
		wr_cnt[0] |=> !g_tmr[0].armed;
	endproperty
	a_arm: assert property (p_arm) else $error("armed after count write"); // [R9]

	property p_wake;
		@(posedge i_mclk) disable iff (i_srst)
		o_wake |-> (ctrl[0][GST_CTL_SYNCDIS] || ctrl[1][GST_CTL_SYNCDIS]);
	endproperty
	a_wake: assert property (p_wake) else $error("wake without async mode"); // [R15]

	property p_tb;
		@(posedge i_mclk) disable iff (i_srst)
		1'b1 |=> o_ccp_time_base == $past(count[0]);
	endproperty
	a_tb: assert property (p_tb) else $error("time base not first counter"); // [R16]

	property p_trig_clr;
		@(posedge i_mclk) disable iff (i_srst)
		(i_ccp_special_trigger && !wr_cnt[0]) |=> count[0] == 16'h0000;
	endproperty
	a_trig_clr: assert property (p_trig_clr) else $error("trigger missed first counter"); // [R16]

	property p_trig_one;
		@(posedge i_mclk) disable iff (i_srst)
		(i_ccp_special_trigger && !ctrl[1][GST_CTL_RUN] && !wr_cnt[1]) |=> $stable(count[1]);
	endproperty
	a_trig_one: assert property (p_trig_one) else $error("trigger hit counter 1"); // [R16]

	property p_gate_hold;
		@(posedge i_mclk) disable iff (i_srst)
		(gate_ctrl[0][GST_GCT_GE] && g_tmr[0].gat_s[1] != gate_ctrl[0][GST_GCT_POL]
			&& !wr_cnt[0] && !i_ccp_special_trigger) |=> $stable(count[0]);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("count moved, gate closed"); // [R18]

	c_ovf0: cover property (@(posedge i_mclk) ovf_evt[0]);
	c_ovf1: cover property (@(posedge i_mclk) ovf_evt[1]);
	c_wake: cover property (@(posedge i_mclk) o_wake);
	c_trig: cover property (@(posedge i_mclk) i_ccp_special_trigger && count[0] != 16'h0000);

endmodule : gst_timer_pair

`default_nettype wire

// file: gst_clk_source.sv
/*
 * Far-side model: count pins, crystal and sense oscillators as levels.
 * Assumes the bench calls pulse() and wires the block's osc enable in.
 */
`timescale 1ns/1ps
`default_nettype none

module gst_clk_source (
	// crystal enable from the block
	input wire logic i_osc_en,
	// levels toward the block
	output logic [1:0] o_pin,
	output logic o_xtal,
	output logic o_sense_a,
	output logic o_sense_b
);
	initial begin
		o_pin = 2'h0;
		o_xtal = 1'b0;
		o_sense_a = 1'b0;
		o_sense_b = 1'b0;
	end

	// crystal swings only once enabled, sleep or not
	// sense a feeds counter 0, sense b counter 1
	task automatic put(input int sel, input logic v);
		case (sel)
			0: o_pin[0] <= v;
			1: o_pin[1] <= v;
			2: o_xtal <= v & i_osc_en;
			3: o_sense_a <= v;
			default: o_sense_b <= v;
		endcase
	endtask : put

	// half is each level time in ns; slow widths model a sluggish source
	task automatic pulse(input int sel, input int n, input int half);
		for (int k = 0; k < n; k++) begin
			put(sel, 1'b1);
			#(half);
			put(sel, 1'b0);
			#(half);
		end
	endtask : pulse
endmodule : gst_clk_source

`default_nettype wire

// file: tb_gated_sixteen_bit_timer_pair.sv
/*
 * Self-checking bench for the timer pair: bus tasks, read-note queue.
 * Assumes gst_pkg, gst_timer_pair and gst_clk_source are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_gated_sixteen_bit_timer_pair;
	import gst_pkg::*;
	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	gst_req_s req = '0;
	gst_rsp_s rsp;
	logic [1:0] gate = 2'h0;
	logic sleep = 1'b0;
	logic trig = 1'b0;
	logic xout, xen, irq, wake, xtal, sa, sb;
	logic [1:0] pin;
	logic [15:0] tbase;
	logic [32:0] expq[$];
	logic [32:0] note;
	logic [31:0] rd, r2, v;
	int errors = 0;
	int checked = 0;

	always #2.5 i_mclk = ~i_mclk;

	gst_timer_pair u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_req(req), .o_rsp(rsp),
		.i_external_count_pin(pin), .i_crystal_input_pin(xtal),
		.i_sense_osc_channel_a(sa), .i_sense_osc_channel_b(sb), .i_gate_input(gate),
		.i_sleep(sleep), .i_ccp_special_trigger(trig), .o_crystal_output_pin(xout),
		.o_crystal_osc_enable(xen), .o_ccp_time_base(tbase), .o_irq(irq), .o_wake(wake));

	gst_clk_source u_src (.i_osc_en(xen), .o_pin(pin), .o_xtal(xtal),
		.o_sense_a(sa), .o_sense_b(sb));

	task automatic end_of_test;
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	// held until waitrequest is seen low at a rising edge
	task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] d,
		input logic chk, input logic [31:0] exp, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_mclk);
		if (!wr)
			expq.push_back({chk, exp});
		req <= '{a, !wr, wr, d};
		// waitrequest and readdata read here still hold their pre-edge values
		do begin
			@(posedge i_mclk);
			n++;
			if (n > 20) begin
				errors++;
				end_of_test();
			end
		end while (rsp.waitrequest !== 1'b0);
		q = rsp.readdata;
		req <= '0;
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(a, 1'b1, {24'h0, d}, 1'b0, 32'h0, rd);
	endtask : wr

	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0, 1'b1, e, rd);
	endtask : rdc

	// two reads 64 cycles apart; low byte difference is the step count
	task automatic step(input logic [7:0] e);
		bus(GST_OFS_CNTL0, 1'b0, 32'h0, 1'b0, 32'h0, rd);
		repeat (61) @(posedge i_mclk);
		bus(GST_OFS_CNTL0, 1'b0, 32'h0, 1'b0, 32'h0, r2);
		cmp("count step", {24'h0, e}, {24'h0, r2[7:0] - rd[7:0]});
	endtask : step

	// stopping first keeps the byte writes free of increment contention
	task automatic setcnt(input int i, input logic [15:0] c);
		wr(GST_OFS_CTRL0 + 6'(16 * i), 8'h00);
		wr(GST_OFS_CNTL0 + 6'(16 * i), c[7:0]);
		wr(GST_OFS_CNTH0 + 6'(16 * i), c[15:8]);
	endtask : setcnt

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1) begin
			@(negedge i_mclk);
			n++;
			if (n > 100) begin
				errors++;
				end_of_test();
			end
		end
	endtask : wait_irq

	always @(negedge i_mclk) begin
		if (req.read && rsp.waitrequest === 1'b0 && expq.size() > 0) begin
			note = expq.pop_front();
			if (note[32])
				cmp("readdata", note[31:0], rsp.readdata);
		end
	end

	initial begin
		logic [5:0] ofs[8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h20, 6'h24, 6'h28, 6'h2C};
		void'($urandom(63987));
		repeat (12) @(posedge i_mclk);
		i_srst <= 1'b0;
		foreach (ofs[k]) rdc(ofs[k], 32'h0);
		cmp("irq", 32'h0, {31'h0, irq});
		for (int i = 0; i < 2; i++) begin
			v = $urandom;
			setcnt(i, v[15:0]);
			rdc(GST_OFS_CNTL0 + 6'(16 * i), {24'h0, v[7:0]});
			rdc(GST_OFS_CNTH0 + 6'(16 * i), {24'h0, v[15:8]});
			if (i == 0)
				cmp("time base", {16'h0, v[15:0]}, {16'h0, tbase});
		end
		// trigger clears the first counter, the second keeps its value
		trig <= 1'b1;
		@(posedge i_mclk);
		trig <= 1'b0;
		rdc(GST_OFS_CNTL0, 32'h0);
		rdc(GST_OFS_CNTH0, 32'h0);
		rdc(GST_OFS_CNTH1, {24'h0, v[15:8]});
		// instruction clock then system clock, every prescale ratio
		for (int cs = 0; cs < 2; cs++) begin
			for (int ps = 0; ps < 4; ps++) begin
				wr(GST_OFS_CTRL0, {cs[1:0], ps[1:0], 4'h1});
				step(8'(64 >> (ps + (cs == 0 ? 2 : 0))));
			end
		end
		wr(GST_OFS_CTRL0, 8'h40);
		step(8'h00);
		for (int g = 0; g < 4; g++) begin
			wr(GST_OFS_GATE0, {1'b1, g[1], 6'h0});
			gate <= {1'b0, g[0]};
			wr(GST_OFS_CTRL0, 8'h41);
			step((g[1] == g[0]) ? 8'd64 : 8'd0);
		end
		wr(GST_OFS_CTRL0, 8'h40);
		step(8'h00);
		wr(GST_OFS_GATE0, 8'h00);
		// pin starts low: first rising edge after the write is not counted
		for (int i = 0; i < 2; i++) begin
			setcnt(i, 16'h0);
			wr(GST_OFS_CTRL0 + 6'(16 * i), 8'h81);
			u_src.pulse(i, 5, 25);
			repeat (10) @(posedge i_mclk);
			rdc(GST_OFS_CNTL0 + 6'(16 * i), 32'h4);
		end
		setcnt(0, 16'h0);
		setcnt(1, 16'h0);
		wr(GST_OFS_CTRL0, 8'hC1);
		wr(GST_OFS_CTRL1, 8'hC1);
		u_src.pulse(3, 3, 25);
		repeat (10) @(posedge i_mclk);
		rdc(GST_OFS_CNTL0, 32'h2);
		rdc(GST_OFS_CNTL1, 32'h0);
		wr(GST_OFS_XOSC, 8'h01);
		@(negedge i_mclk);
		cmp("osc enable", 32'h1, {31'h0, xen});
		cmp("osc drive", 32'h1, {31'h0, xout});
		repeat (50) @(posedge i_mclk);
		setcnt(0, 16'h0);
		setcnt(1, 16'h0);
		wr(GST_OFS_CTRL0, 8'h81);
		wr(GST_OFS_CTRL1, 8'h81);
		u_src.pulse(2, 4, 25);
		repeat (10) @(posedge i_mclk);
		rdc(GST_OFS_CNTL0, 32'h3);
		rdc(GST_OFS_CNTL1, 32'h3);
		wr(GST_OFS_XOSC, 8'h00);
		wr(GST_OFS_CTRL1, 8'h00);
		wr(GST_OFS_MASK, 8'h01);
		setcnt(0, 16'hFFFE);
		wr(GST_OFS_CTRL0, 8'h41);
		wait_irq();
		wr(GST_OFS_CTRL0, 8'h00);
		rdc(GST_OFS_STAT, 32'h1);
		rdc(GST_OFS_STAT, 32'h0);
		cmp("irq", 32'h0, {31'h0, irq});
		wr(GST_OFS_MASK, 8'h00);
		setcnt(1, 16'hFFFF);
		wr(GST_OFS_CTRL1, 8'h41);
		repeat (20) @(posedge i_mclk);
		wr(GST_OFS_CTRL1, 8'h00);
		cmp("irq", 32'h0, {31'h0, irq});
		rdc(GST_OFS_STAT, 32'h2);
		// asynchronous external overflow in sleep wakes, synchronised does not
		for (int sd = 1; sd >= 0; sd--) begin
			wr(GST_OFS_MASK, 8'h01);
			setcnt(0, 16'hFFFF);
			sleep <= 1'b1;
			wr(GST_OFS_CTRL0, {5'h10, sd[0], 2'h1});
			u_src.pulse(0, 2, 25);
			wait_irq();
			cmp("wake", {31'h0, sd[0]}, {31'h0, wake});
			sleep <= 1'b0;
			wr(GST_OFS_CTRL0, 8'h00);
			rdc(GST_OFS_STAT, 32'h1);
		end
		end_of_test();
	end
endmodule : tb_gated_sixteen_bit_timer_pair

`default_nettype wire
